// >>> rtl/rsu_port.sv
// RS485 UART port: host decode, registers, baud, transmit, receive
`timescale 1ns/1ps
`default_nettype none
module rsu_port (
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    input  wire rsu_pkg::rsu_bus_req_t BUS,
    input  wire logic [6:0]            SWITCH_OFF,
    input  wire logic                  AUTO_DRV,
    input  wire logic                  ECHO_EN,
    input  wire logic                  RXD,
    output logic      [7:0]            D_OUT,
    output logic                       D_OE_N,
    output logic                       IRQ,
    output logic                       TXD,
    output logic                       RTS,
    output logic                       DRV_EN,
    output logic                       RX_EN
);
    import rsu_pkg::*;

    function automatic logic [7:0] len_mask(input logic [1:0] wls);
        len_mask = 8'hff >> (3'h3 - {1'b0, wls});
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input rsu_lcr_t l);
        logic [7:0] m;
        m = d & len_mask(l.wls);
        if (l.stick) begin
            par_bit = ~l.eps;
        end else begin
            par_bit = l.eps ? ^m : ~^m;
        end
    endfunction

    function automatic logic [2:0] last_idx(input logic [1:0] wls);
        last_idx = {1'b0, wls} + WLS_BASE;
    endfunction

    // ============================================================
    // Host decode
    logic       hit;
    logic [2:0] ofs;
    logic       rd_hit;
    logic       wr_hit;
    assign hit    = (BUS.addr[ADDR_HI:ADDR_LO] == SWITCH_OFF);
    assign ofs    = BUS.addr[OFS_HI:0];
    assign rd_hit = BUS.rd & hit;
    assign wr_hit = BUS.wr & hit;

    // ============================================================
    // Software registers
    rsu_lcr_t         lcr_r;
    logic [MCR_W-1:0] mcr_r;
    logic [IER_W-1:0] ier_r;
    logic [15:0]      div_r;
    logic [7:0]       scr_r;
    logic             dsel;
    assign dsel = lcr_r.divisor_access_select;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            lcr_r <= LCR_RST;
            mcr_r <= MCR_RST;
            ier_r <= '0;
            div_r <= DIV_RST;
            scr_r <= 8'h00;
        end else if (wr_hit) begin
            case (ofs)
                OFS_DATA: if (dsel) div_r[7:0] <= BUS.wdata;
                OFS_IER: begin
                    if (dsel) begin
                        div_r[15:8] <= BUS.wdata;
                    end else begin
                        ier_r <= BUS.wdata[IER_W-1:0];
                    end
                end
                OFS_LCR: lcr_r <= BUS.wdata;
                OFS_MCR: mcr_r <= BUS.wdata[MCR_W-1:0];
                OFS_SCR: scr_r <= BUS.wdata;
                default: ;
            endcase
        end
    end

    // ============================================================
    // Baud ticks: crystal rate, halved, then divided to 16x bit rate
    logic [NCO_W-1:0] nco_r;
    logic [NCO_W:0]   nco_sum;
    logic             xt_r;
    logic             half_r;
    logic [15:0]      bdc_r;
    logic             h_tick;
    logic             tick16;
    assign nco_sum = {1'b0, nco_r} + NCO_STEP;
    assign h_tick  = xt_r & half_r;
    // Divisor zero stops the clock instead of running at an odd rate
    assign tick16  = h_tick && (div_r != DIV_RST)
                     && (bdc_r == div_r - 16'h0001);
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            nco_r  <= '0;
            xt_r   <= 1'b0;
            half_r <= 1'b0;
            bdc_r  <= '0;
        end else begin
            xt_r <= (nco_sum >= NCO_MOD);
            if (nco_sum >= NCO_MOD) begin
                nco_r <= NCO_W'(nco_sum - NCO_MOD);
            end else begin
                nco_r <= nco_sum[NCO_W-1:0];
            end
            if (xt_r) begin
                half_r <= ~half_r;
            end
            if (h_tick) begin
                bdc_r <= (tick16 || bdc_r >= div_r) ? 16'h0000
                                                    : bdc_r + 16'h0001;
            end
        end
    end

    // ============================================================
    // Transmitter
    rsu_ser_st_t tx_st_r;
    logic [7:0]  thr_r;
    logic        thr_full_r;
    logic [7:0]  tx_sh_r;
    logic        tx_par_r;
    logic [3:0]  tx_cnt_r;
    logic [2:0]  tx_idx_r;
    logic        tx_load;
    logic        tx_end;
    logic        tx_done;
    logic        thr_wr;
    assign thr_wr  = wr_hit && ofs == OFS_DATA && !dsel;
    assign tx_load = (tx_st_r == ST_IDLE) && thr_full_r;
    assign tx_end  = tick16 && tx_cnt_r == OVS_LAST;
    assign tx_done = (tx_st_r == ST_STOP) && tx_end
                     && !(lcr_r.stb && tx_idx_r == 3'h0);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            thr_r      <= 8'h00;
            thr_full_r <= 1'b0;
        end else if (thr_wr) begin
            thr_r      <= BUS.wdata;
            thr_full_r <= 1'b1;
        end else if (tx_load) begin
            thr_full_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            tx_st_r  <= ST_IDLE;
            tx_sh_r  <= 8'h00;
            tx_par_r <= 1'b0;
            tx_cnt_r <= '0;
            tx_idx_r <= '0;
        end else begin
            if (tx_st_r == ST_IDLE) begin
                tx_cnt_r <= '0;
            end else if (tick16) begin
                tx_cnt_r <= tx_cnt_r + 4'h1;
            end
            case (tx_st_r)
                ST_IDLE: if (tx_load) begin
                    tx_sh_r  <= thr_r;
                    tx_par_r <= par_bit(thr_r, lcr_r);
                    tx_st_r  <= ST_START;
                end
                ST_START: if (tx_end) begin
                    tx_idx_r <= '0;
                    tx_st_r  <= ST_DATA;
                end
                ST_DATA: if (tx_end) begin
                    tx_sh_r  <= tx_sh_r >> 1;
                    tx_idx_r <= tx_idx_r + 3'h1;
                    if (tx_idx_r == last_idx(lcr_r.wls)) begin
                        tx_idx_r <= '0;
                        tx_st_r  <= lcr_r.pen ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: if (tx_end) begin
                    tx_idx_r <= '0;
                    tx_st_r  <= ST_STOP;
                end
                ST_STOP: if (tx_end) begin
                    if (tx_done) begin
                        tx_st_r <= ST_IDLE;
                    end else begin
                        tx_idx_r <= 3'h1;
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TXD <= 1'b1;
        end else if (lcr_r.brk) begin
            TXD <= 1'b0;
        end else begin
            case (tx_st_r)
                ST_START: TXD <= 1'b0;
                ST_DATA:  TXD <= tx_sh_r[0];
                ST_PAR:   TXD <= tx_par_r;
                default:  TXD <= 1'b1;
            endcase
        end
    end

    // ============================================================
    // Driver control: hold covers one character time at current format
    logic [7:0] hold_r;
    logic       drv_auto;
    assign drv_auto = thr_full_r || tx_st_r != ST_IDLE || hold_r != 8'h00;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            hold_r <= 8'h00;
            DRV_EN <= 1'b0;
        end else begin
            if (tx_done) begin
                hold_r <= {CHAR_BASE + {2'b00, lcr_r.wls}
                           + {3'b000, lcr_r.pen}
                           + {3'b000, lcr_r.stb}, 4'h0};
            end else if (tick16 && hold_r != 8'h00) begin
                hold_r <= hold_r - 8'h01;
            end
            DRV_EN <= AUTO_DRV ? drv_auto
                               : mcr_r[MCR_RTS];
        end
    end
    assign RTS   = mcr_r[MCR_RTS];
    assign RX_EN = ECHO_EN | ~DRV_EN;

    // ============================================================
    // Receiver
    rsu_ser_st_t      rx_st_r;
    logic             rx_line;
    logic [7:0]       rx_sh_r;
    logic             rx_par_r;
    logic [3:0]       rx_cnt_r;
    logic [2:0]       rx_idx_r;
    logic             rx_smp;
    logic             rx_push;
    logic [RX_AW:0]   wp_r;
    logic [RX_AW:0]   rp_r;
    logic             full;
    logic             pop;
    logic             dr_r;
    logic [7:0]       mem_q;
    logic             oe_r;
    logic             pe_r;
    logic             fe_r;
    logic             bi_r;
    logic             lsr_rd;
    // Echo off: line reads idle while driving, so no self-reception
    assign rx_line = !DRV_EN ? RXD : (ECHO_EN ? TXD : 1'b1);
    assign rx_smp  = tick16 && rx_cnt_r == OVS_LAST;
    assign rx_push = (rx_st_r == ST_STOP) && rx_smp;
    assign full    = (wp_r[RX_AW] != rp_r[RX_AW])
                     && (wp_r[RX_AW-1:0] == rp_r[RX_AW-1:0]);
    assign pop     = rd_hit && ofs == OFS_DATA && !dsel && dr_r;
    assign lsr_rd  = rd_hit && ofs == OFS_LSR;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rx_st_r  <= ST_IDLE;
            rx_sh_r  <= 8'h00;
            rx_par_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_idx_r <= '0;
        end else begin
            if (rx_st_r == ST_IDLE) begin
                rx_cnt_r <= '0;
            end else if (tick16) begin
                rx_cnt_r <= rx_cnt_r + 4'h1;
            end
            case (rx_st_r)
                ST_IDLE: if (!rx_line) begin
                    rx_sh_r <= 8'h00;
                    rx_st_r <= ST_START;
                end
                ST_START: if (tick16 && rx_cnt_r == OVS_HALF) begin
                    // Re-centre on mid-bit; a glitch aborts the frame
                    rx_cnt_r <= '0;
                    rx_idx_r <= '0;
                    rx_st_r  <= rx_line ? ST_IDLE : ST_DATA;
                end
                ST_DATA: if (rx_smp) begin
                    rx_sh_r[rx_idx_r] <= rx_line;
                    rx_idx_r <= rx_idx_r + 3'h1;
                    if (rx_idx_r == last_idx(lcr_r.wls)) begin
                        rx_st_r <= lcr_r.pen ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: if (rx_smp) begin
                    rx_par_r <= rx_line;
                    rx_st_r  <= ST_STOP;
                end
                ST_STOP: if (rx_smp) rx_st_r <= ST_IDLE;
                default: rx_st_r <= ST_IDLE;
            endcase
        end
    end

    // Error flags: a new event in the clearing cycle wins
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            oe_r <= 1'b0;
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            bi_r <= 1'b0;
        end else begin
            oe_r <= (rx_push && full) || (oe_r && !lsr_rd);
            pe_r <= (rx_push && lcr_r.pen
                     && rx_par_r != par_bit(rx_sh_r, lcr_r))
                    || (pe_r && !lsr_rd);
            fe_r <= (rx_push && !rx_line) || (fe_r && !lsr_rd);
            bi_r <= (rx_push && !rx_line && rx_sh_r == 8'h00)
                    || (bi_r && !lsr_rd);
        end
    end

    // Overrun drops the newest character and keeps the stored ones
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wp_r <= '0;
            rp_r <= '0;
            dr_r <= 1'b0;
        end else begin
            if (rx_push && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            dr_r <= (wp_r != rp_r);
        end
    end

    rsu_rxmem u_rxmem (
        .clk   (CLK),
        .rst_n (NRST),
        .we    (rx_push && !full),
        .waddr (wp_r[RX_AW-1:0]),
        .wdata (rx_sh_r),
        .raddr (rp_r[RX_AW-1:0]),
        .rdata (mem_q)
    );

    // ============================================================
    // Interrupt source and host read path
    logic       thre_int_r;
    logic       thre;
    logic       temt;
    logic [7:0] iir_val;
    logic [7:0] rd_val;
    assign thre = ~thr_full_r;
    assign temt = thre && tx_st_r == ST_IDLE;
    always_comb begin
        if (ier_r[IER_RX] && dr_r) begin
            iir_val = IIR_RDA;
        end else if (ier_r[IER_TX] && thre_int_r) begin
            iir_val = IIR_THRE;
        end else begin
            iir_val = IIR_NONE;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            thre_int_r <= 1'b0;
        end else begin
            thre_int_r <= tx_load || (thre_int_r && !thr_wr
                          && !(rd_hit && ofs == OFS_IIR
                               && iir_val == IIR_THRE));
        end
    end

    always_comb begin
        case (ofs)
            OFS_DATA: rd_val = dsel ? div_r[7:0]
                                    : (dr_r ? mem_q : 8'h00);
            OFS_IER:  rd_val = dsel ? div_r[15:8]
                                    : {6'h00, ier_r};
            OFS_IIR:  rd_val = iir_val;
            OFS_LCR:  rd_val = lcr_r;
            OFS_MCR:  rd_val = {3'h0, mcr_r};
            OFS_LSR:  rd_val = {1'b0, temt, thre, bi_r, fe_r, pe_r,
                                oe_r, dr_r};
            OFS_SCR:  rd_val = scr_r;
            default:  rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            D_OUT  <= 8'h00;
            D_OE_N <= 1'b1;
            IRQ    <= 1'b0;
        end else begin
            D_OE_N <= ~rd_hit;
            if (rd_hit) begin
                D_OUT <= rd_val;
            end
            // Modem control bit 2 is stored but steers nothing
            IRQ <= mcr_r[MCR_IRQG] && iir_val != IIR_NONE;
        end
    end

    // ============================================================
    // Checks
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    property p_nohit;
        BUS.rd && !hit |=> D_OE_N;
    endproperty
    a_nohit: assert property (p_nohit) else $error("Answered foreign address");

    property p_hit_rd;
        rd_hit && ofs == OFS_LCR |=> !D_OE_N && D_OUT == $past(lcr_r);
    endproperty
    a_hit_rd: assert property (p_hit_rd) else $error("Decoded read lost");

    property p_div_wr;
        wr_hit && ofs == OFS_DATA && dsel && !thr_full_r
            |=> !thr_full_r;
    endproperty
    a_div_wr: assert property (p_div_wr) else $error("Divisor write hit THR");

    property p_thr;
        thr_wr |=> thr_full_r ##0 !thre;
    endproperty
    a_thr: assert property (p_thr) else $error("THR write not taken");

    property p_pop;
        pop |=> rp_r == $past(rp_r) + 1'b1;
    endproperty
    a_pop: assert property (p_pop) else $error("Data read did not pop");

    property p_dr;
        wp_r != rp_r && !pop |=> dr_r;
    endproperty
    a_dr: assert property (p_dr) else $error("Data ready missing");

    property p_rts;
        !AUTO_DRV |=> DRV_EN == $past(mcr_r[MCR_RTS]);
    endproperty
    a_rts: assert property (p_rts) else $error("Manual driver wrong");

    property p_auto;
        AUTO_DRV && tx_st_r != ST_IDLE |=> DRV_EN;
    endproperty
    a_auto: assert property (p_auto) else $error("Auto driver dropped");

    property p_irq;
        !mcr_r[MCR_IRQG] |=> !IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not gated");

    property p_iir;
        ier_r[IER_RX] && dr_r |-> iir_val == IIR_RDA;
    endproperty
    a_iir: assert property (p_iir) else $error("Receive cause missing");

    property p_start;
        tx_st_r == ST_START && !lcr_r.brk |=> !TXD;
    endproperty
    a_start: assert property (p_start) else $error("Start bit not low");

    c_push: cover property (rx_push && !full);
    c_done: cover property (tx_done);
    c_pop:  cover property (pop);
endmodule
`default_nettype wire

// >>> rtl/rsu_pkg.sv
// Constants and types for the RS485 UART port with switch address decode
`default_nettype none
// ============================================================
package rsu_pkg;
    // ============================================================
    // Clocking: crystal rate is synthesised by a phase accumulator
    localparam int          CLK_HZ   = 100_000_000;
    localparam int          XTAL_HZ  = 3_686_400;
    localparam int          NCO_W    = 20;
    localparam logic [20:0] NCO_MOD  = 21'(CLK_HZ / 100);
    localparam logic [20:0] NCO_STEP = 21'(XTAL_HZ / 100);
    localparam logic [3:0]  OVS_LAST = 4'hf;
    localparam logic [3:0]  OVS_HALF = 4'h7;

    // ============================================================
    // Host decode and register offsets
    localparam int         ADDR_HI  = 9;
    localparam int         ADDR_LO  = 3;
    localparam int         OFS_HI   = 2;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER  = 3'h1;
    localparam logic [2:0] OFS_IIR  = 3'h2;
    localparam logic [2:0] OFS_LCR  = 3'h3;
    localparam logic [2:0] OFS_MCR  = 3'h4;
    localparam logic [2:0] OFS_LSR  = 3'h5;
    localparam logic [2:0] OFS_SCR  = 3'h7;

    // ============================================================
    // Field positions and reset values
    localparam int          MCR_RTS   = 1;
    localparam int          MCR_IRQG  = 3;
    localparam int          MCR_W     = 5;
    localparam int          IER_RX    = 0;
    localparam int          IER_TX    = 1;
    localparam int          IER_W     = 2;
    localparam logic [7:0]  LCR_RST   = 8'h00;
    localparam logic [4:0]  MCR_RST   = 5'h00;
    localparam logic [15:0] DIV_RST   = 16'h0000;
    localparam logic [7:0]  IIR_NONE  = 8'h01;
    localparam logic [7:0]  IIR_THRE  = 8'h02;
    localparam logic [7:0]  IIR_RDA   = 8'h04;
    localparam logic [2:0]  WLS_BASE  = 3'h4;
    localparam logic [3:0]  CHAR_BASE = 4'h7;

    // ============================================================
    // Receive store
    localparam int RX_AW = 4;

    typedef struct packed {
        logic       divisor_access_select;
        logic       brk;
        logic       stick;
        logic       eps;
        logic       pen;
        logic       stb;
        logic [1:0] wls;
    } rsu_lcr_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } rsu_bus_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PAR,
        ST_STOP
    } rsu_ser_st_t;
endpackage
`default_nettype wire

// >>> rtl/rsu_rxmem.sv
// Receive character store with registered read data
`timescale 1ns/1ps
`default_nettype none
module rsu_rxmem (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     we,
    input  wire logic [rsu_pkg::RX_AW-1:0] waddr,
    input  wire logic [7:0]               wdata,
    input  wire logic [rsu_pkg::RX_AW-1:0] raddr,
    output logic      [7:0]               rdata
);
    import rsu_pkg::*;

    logic [7:0] mem [2**RX_AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port registered so the host data path sees a clean flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// >>> verification/rsu_host.sv
// Host bus master model for the port's register bus
`timescale 1ns/1ps
`default_nettype none
module rsu_host (
    input  wire logic             clk,
    input  wire logic [7:0]       d_out,
    input  wire logic             d_oe_n,
    output var rsu_pkg::rsu_bus_req_t bus
);
    import rsu_pkg::*;
    initial bus = '0;
    // One-cycle strobe; the next call waits a negedge, so one idle cycle
    task automatic acc(input logic w, input logic [9:0] a,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic hit);
        @(negedge clk);
        bus = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        bus = '0;
        hit = !d_oe_n;
        q = d_out;
    endtask
endmodule
`default_nettype wire

// >>> verification/rsu_port_tb.sv
// Self-checking bench for the RS485 UART port
`timescale 1ns/1ps
`default_nettype none
module rsu_port_tb;
    import rsu_pkg::*;
    localparam logic [9:0] BASE = 10'h2d8;
    logic         clk = 0, nrst = 0, auto_drv = 0, echo_en = 1, hit;
    logic         rxd = 1;
    logic         d_oe_n, irq, txd, rts, drv_en, rx_en;
    logic [7:0]   d_out, q, b;
    rsu_bus_req_t bus;
    int           miscompares = 0, check_count = 0, seed = 24296;
    logic [7:0]   exp_q[$];
    always #5 clk = ~clk;
    rsu_host host_u (.clk(clk), .d_out(d_out), .d_oe_n(d_oe_n), .bus(bus));
    rsu_port dut_u (.CLK(clk), .NRST(nrst), .BUS(bus),
        .SWITCH_OFF(BASE[9:3]), .AUTO_DRV(auto_drv), .ECHO_EN(echo_en),
        .RXD(rxd), .D_OUT(d_out), .D_OE_N(d_oe_n), .IRQ(irq), .TXD(txd),
        .RTS(rts), .DRV_EN(drv_en), .RX_EN(rx_en));
    task automatic chk(input string n, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [2:0] o, input logic [7:0] d);
        host_u.acc(1'b1, BASE | 10'(o), d, q, hit);
    endtask
    task automatic rd(input logic [2:0] o);
        host_u.acc(1'b0, BASE | 10'(o), 8'h00, q, hit);
    endtask
    // Sample each bit mid-cell; divisor 1 gives 868 clocks a bit
    // Returns at mid stop bit so a back-to-back start is not missed
    task automatic frame(input logic [9:0] f);
        int i;
        i = 0;
        while (txd === 1'b1 && i < 2000) begin
            @(negedge clk);
            i++;
        end
        chk("drv", {7'h0, drv_en}, 8'h01);
        repeat (434) @(negedge clk);
        for (i = 0; i < 10; i++) begin
            if (i > 0) begin
                repeat (868) @(negedge clk);
            end
            chk("txbit", {7'h0, txd}, {7'h0, f[i]});
        end
    endtask
    // Far end drives one frame on the receive line, 868 clocks a bit
    task automatic send(input logic [9:0] f);
        int i;
        for (i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (868) @(negedge clk);
        end
    endtask
    // Drain the receive store and compare against the model queue
    task automatic drain;
        repeat (30) @(negedge clk);
        rd(OFS_LSR);
        chk("ready", {7'h0, q[0]}, 8'h01);
        chk("thre_hi", {7'h0, q[5]}, 8'h01);
        rd(OFS_IIR);
        chk("iir", q, IIR_RDA);
        while (exp_q.size() > 0) begin
            rd(OFS_DATA);
            chk("rx_data", q, exp_q.pop_front());
        end
        rd(OFS_LSR);
        chk("empty", {7'h0, q[0]}, 8'h00);
        chk("irq_clr", {7'h0, irq}, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Traffic takes about 55k clocks; the limit allows half as much again
    initial begin
        #800_000;
        miscompares++;
        results();
    end
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1;
        chk("txd_rst", {7'h0, txd}, 8'h01);
        wr(OFS_LCR, 8'h80);
        wr(OFS_DATA, 8'h01);
        wr(OFS_IER, 8'h00);
        rd(OFS_DATA);
        chk("dll", q, 8'h01);
        rd(OFS_IER);
        chk("dlm", q, 8'h00);
        host_u.acc(1'b0, BASE ^ 10'h008, 8'h00, q, hit);
        chk("foreign", {7'h0, hit}, 8'h00);
        wr(OFS_LCR, 8'h03);
        rd(OFS_LCR);
        chk("lcr", q, 8'h03);
        wr(OFS_IER, 8'h01);
        wr(OFS_MCR, 8'h0a);
        chk("rts", {7'h0, rts}, 8'h01);
        b = 8'($random(seed));
        exp_q = {b, ~b};
        wr(OFS_DATA, b);
        wr(OFS_DATA, ~b);
        rd(OFS_LSR);
        chk("thre", {7'h0, q[5]}, 8'h00);
        frame({1'b1, b, 1'b0});
        frame({1'b1, ~b, 1'b0});
        chk("irq", {7'h0, irq}, 8'h01);
        drain();
        auto_drv = 1;
        wr(OFS_MCR, 8'h08);
        chk("rts_off", {7'h0, rts}, 8'h00);
        // Seven data bits and two stop bits from here on
        wr(OFS_LCR, 8'h06);
        b = 8'($random(seed));
        exp_q = {b & 8'h7f};
        wr(OFS_DATA, b);
        frame({2'b11, b[6:0], 1'b0});
        drain();
        repeat (4000) @(negedge clk);
        chk("hold", {7'h0, drv_en}, 8'h01);
        repeat (6000) @(negedge clk);
        chk("release", {7'h0, drv_en}, 8'h00);
        chk("rx_en", {7'h0, rx_en}, 8'h01);
        b = 8'($random(seed));
        exp_q = {b & 8'h7f};
        send({2'b11, b[6:0], 1'b0});
        drain();
        echo_en = 0;
        wr(OFS_DATA, b);
        frame({2'b11, b[6:0], 1'b0});
        chk("rx_off", {7'h0, rx_en}, 8'h00);
        rd(OFS_LSR);
        chk("no_echo", {7'h0, q[0]}, 8'h00);
        results();
    end
endmodule
`default_nettype wire
